// ### logic/ptm_timer.v
// Prescaled 8-bit timer/counter with register port and interrupt
//
// Function
// R1 - Prescaler sits in count path only while bypass bit is clear; timer-only use.
// R2 - Eight prescale ratios, 1:2 to 1:256, picked by three-bit select.
// R3 - Bypass bit set gives an undivided 1:1 count rate.
// R4 - Prescaler count is never readable nor directly writable.
// R5 - Any write to the count register clears the prescaler.
// R6 - Rollover from FFh to 00h raises the overflow event.
// R7 - Overflow flag sets on every rollover, enable bit regardless.
// R8 - Hardware never clears overflow flag; software must clear it.
// R9 - Overflow flag requests interrupt only while its enable bit is set.
// R10 - Watchdog has its own separate prescaler.
// R11 - External edges synchronised by sampling prescaler output on Q2 and Q4.
// R12 - During sleep counting stops and count register holds.
// R13 - Timer overflow cannot wake from sleep; timer is frozen.
// R14 - Timer mode counts each instruction cycle, or each prescaler pulse.
// R15 - After a count write, counting resumes upward from written value.
//
// Design decisions made here: the address map and the strobed register port.
`timescale 1ns/10ps
`include "ptm_defs.vh"
module ptm_timer (
   ref_clk,
   reset,
   reg_addr,
   reg_wdata,
   reg_wr,
   reg_rd,
   reg_rdata,
   ext_count_input,
   sleep_mode,
   irq,
   watchdog_tick
);
   input wire ref_clk;
   input wire reset;
   input wire [`PTM_ADDR_W-1:0] reg_addr;
   input wire [`PTM_DATA_W-1:0] reg_wdata;
   input wire reg_wr;
   input wire reg_rd;
   output reg [`PTM_DATA_W-1:0] reg_rdata;
   input wire ext_count_input;
   input wire sleep_mode;
   output reg irq;
   output reg watchdog_tick;

   // ----------------------------------------
   // Instruction clock quarter phases
   // ----------------------------------------
   localparam [3:0] PH_Q1 = 4'b0001;
   localparam [3:0] PH_Q2 = 4'b0010;
   localparam [3:0] PH_Q3 = 4'b0100;
   localparam [3:0] PH_Q4 = 4'b1000;

   reg [3:0] phase_q;
   reg [3:0] phase_d;

   always @* begin
      case (phase_q)
         PH_Q1: phase_d = PH_Q2;
         PH_Q2: phase_d = PH_Q3;
         PH_Q3: phase_d = PH_Q4;
         PH_Q4: phase_d = PH_Q1;
         default: phase_d = PH_Q1;
      endcase
   end

   always @(posedge ref_clk) begin
      if (reset) begin
         phase_q <= PH_Q1;
      end else begin
         phase_q <= phase_d;
      end
   end

   wire second_quarter_phase;
   wire fourth_quarter_phase;
   assign second_quarter_phase = (phase_q == PH_Q2);
   assign fourth_quarter_phase = (phase_q == PH_Q4);

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   reg [7:0] count_value_q;
   reg [7:0] option_q;
   reg global_irq_enable_q;
   reg peripheral_irq_enable_q;
   reg overflow_irq_enable_q;
   reg overflow_flag_q;
   reg [`PTM_EVT_W-1:0] evt_stat_q;
   reg [`PTM_EVT_W-1:0] evt_mask_q;
   reg [2:0] wdt_select_q;

   wire wr_count;
   wire wr_option;
   wire wr_intctl;
   wire wr_mask;
   wire wr_wdt;
   wire rd_stat;
   assign wr_count = reg_wr && (reg_addr == `PTM_OFS_COUNT);
   assign wr_option = reg_wr && (reg_addr == `PTM_OFS_OPTION);
   assign wr_intctl = reg_wr && (reg_addr == `PTM_OFS_INTCTL);
   assign wr_mask = reg_wr && (reg_addr == `PTM_OFS_EVT_MASK);
   assign wr_wdt = reg_wr && (reg_addr == `PTM_OFS_WDT_CFG);
   assign rd_stat = reg_rd && (reg_addr == `PTM_OFS_EVT_STAT);

   wire prescaler_bypass;
   wire [2:0] prescale_select;
   wire edge_falling;
   wire ext_mode;
   assign prescaler_bypass = option_q[`PTM_OPT_BYPASS];
   assign prescale_select = option_q[`PTM_OPT_PS_MSB:`PTM_OPT_PS_LSB];
   assign edge_falling = option_q[`PTM_OPT_EDGE];
   assign ext_mode = option_q[`PTM_OPT_EXT_MODE];

   // ----------------------------------------
   // External count edge detection
   // ----------------------------------------
   reg ext_prev_q;
   wire ext_level;
   wire ext_rise;
   assign ext_level = ext_count_input ^ edge_falling;
   assign ext_rise = ext_level & ~ext_prev_q;

   // Reset to the idle level under the reset option (falling edge, pin low),
   // so release of reset is not taken for an edge
   always @(posedge ref_clk) begin
      if (reset) begin
         ext_prev_q <= 1'b1;
      end else begin
         ext_prev_q <= ext_level;
      end
   end

   // ----------------------------------------
   // Timer prescaler
   // ----------------------------------------
   wire pre_step;
   wire pre_level;
   wire pre_tick;
   // Dedicated to this timer; bypass simply routes around it
   assign pre_step = ~prescaler_bypass & (ext_mode ? ext_rise : fourth_quarter_phase); // see R1

   ptm_prescaler u_timer_pre (
      .ref_clk(ref_clk),
      .reset(reset),
      .clear(wr_count), // see R5
      .hold(sleep_mode), // see R12
      .step(pre_step),
      .sel(prescale_select), // see R2
      .level(pre_level),
      .tick(pre_tick)
   );

   // ----------------------------------------
   // Quarter phase synchroniser for counter mode
   // ----------------------------------------
   reg samp_q2_q;
   reg samp_q4_q;
   wire src_level;
   // Bypassed counter mode samples the pin level itself
   assign src_level = prescaler_bypass ? ext_level : pre_level; // see R3

   always @(posedge ref_clk) begin
      if (reset) begin
         samp_q2_q <= 1'b1;
         samp_q4_q <= 1'b1;
      end else if (!sleep_mode) begin
         if (second_quarter_phase) begin
            samp_q2_q <= src_level; // see R11
         end
         if (fourth_quarter_phase) begin
            samp_q4_q <= samp_q2_q; // see R11
         end
      end
   end

   // ----------------------------------------
   // Count increment
   // ----------------------------------------
   wire inc_ext;
   wire inc_tmr;
   wire inc;
   wire rollover;
   // Edge counted only at Q4, so pulses shorter than an instruction cycle may be lost
   assign inc_ext = fourth_quarter_phase & samp_q2_q & ~samp_q4_q; // see R11
   assign inc_tmr = fourth_quarter_phase & (prescaler_bypass | pre_tick); // see R14
   // Frozen timer cannot produce an overflow to wake from sleep
   assign inc = ~sleep_mode & (ext_mode ? inc_ext : inc_tmr); // see R12 R13
   assign rollover = inc & ~wr_count & (count_value_q == `PTM_COUNT_MAX); // see R6

   always @(posedge ref_clk) begin
      if (reset) begin
         count_value_q <= `PTM_ZERO8;
      end else if (wr_count) begin
         count_value_q <= reg_wdata; // see R15
      end else if (inc) begin
         count_value_q <= count_value_q + 8'h01; // see R15
      end
   end

   // ----------------------------------------
   // Control and interrupt registers
   // ----------------------------------------
   always @(posedge ref_clk) begin
      if (reset) begin
         option_q <= `PTM_OPT_RESET;
         global_irq_enable_q <= 1'b0;
         peripheral_irq_enable_q <= 1'b0;
         overflow_irq_enable_q <= 1'b0;
         overflow_flag_q <= 1'b0;
         evt_mask_q <= `PTM_ZERO_EVT;
         wdt_select_q <= `PTM_WDT_RESET;
      end else begin
         if (wr_option) begin
            option_q <= reg_wdata;
         end
         if (wr_mask) begin
            evt_mask_q <= reg_wdata[`PTM_EVT_W-1:0];
         end
         if (wr_wdt) begin
            wdt_select_q <= reg_wdata[2:0];
         end
         if (wr_intctl) begin
            global_irq_enable_q <= reg_wdata[`PTM_IC_GLOBAL_EN];
            peripheral_irq_enable_q <= reg_wdata[`PTM_IC_PERIPH_EN];
            overflow_irq_enable_q <= reg_wdata[`PTM_IC_OVF_EN];
         end
         // Set beats a software clear in the same cycle
         if (rollover) begin
            overflow_flag_q <= 1'b1; // see R7
         end else if (wr_intctl) begin
            overflow_flag_q <= reg_wdata[`PTM_IC_OVF_FLAG]; // see R8
         end
      end
   end

   // ----------------------------------------
   // Watchdog prescaler, separate from the timer
   // ----------------------------------------
   wire wdt_tick;

   ptm_prescaler u_wdt_pre (
      .ref_clk(ref_clk),
      .reset(reset),
      .clear(wr_wdt),
      .hold(1'b0),
      .step(fourth_quarter_phase),
      .sel(wdt_select_q), // see R10
      .level(),
      .tick(wdt_tick)
   );

   // ----------------------------------------
   // Event status, read clears
   // ----------------------------------------
   wire [`PTM_EVT_W-1:0] evt_set;
   assign evt_set = {wdt_tick, rollover};

   always @(posedge ref_clk) begin
      if (reset) begin
         evt_stat_q <= `PTM_ZERO_EVT;
      end else if (rd_stat) begin
         evt_stat_q <= evt_set;
      end else begin
         evt_stat_q <= evt_stat_q | evt_set;
      end
   end

   // ----------------------------------------
   // Read port and outputs
   // ----------------------------------------
   reg [7:0] rdata_d;
   wire [7:0] intctl_view;
   assign intctl_view = {global_irq_enable_q, peripheral_irq_enable_q, overflow_irq_enable_q,
                         2'b00, overflow_flag_q, 2'b00};

   // Prescaler count is deliberately absent from the map
   always @* begin
      rdata_d = `PTM_ZERO8; // see R4
      case (reg_addr)
         `PTM_OFS_COUNT: rdata_d = count_value_q;
         `PTM_OFS_OPTION: rdata_d = option_q;
         `PTM_OFS_INTCTL: rdata_d = intctl_view;
         `PTM_OFS_EVT_STAT: rdata_d = {6'h00, evt_stat_q};
         `PTM_OFS_EVT_MASK: rdata_d = {6'h00, evt_mask_q};
         `PTM_OFS_WDT_CFG: rdata_d = {5'h00, wdt_select_q};
         default: rdata_d = `PTM_ZERO8;
      endcase
   end

   always @(posedge ref_clk) begin
      if (reset) begin
         reg_rdata <= `PTM_ZERO8;
         irq <= 1'b0;
         watchdog_tick <= 1'b0;
      end else begin
         reg_rdata <= reg_rd ? rdata_d : `PTM_ZERO8;
         irq <= (|(evt_stat_q & evt_mask_q))
                | (overflow_flag_q & overflow_irq_enable_q & global_irq_enable_q); // see R9
         watchdog_tick <= wdt_tick;
      end
   end
endmodule // ptm_timer

// ### logic/ptm_defs.vh
// Register map, field positions and constants of the prescaled 8-bit timer
`ifndef PTM_DEFS_VH
`define PTM_DEFS_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define PTM_ADDR_W 4
`define PTM_DATA_W 8
`define PTM_OFS_COUNT 4'h0
`define PTM_OFS_OPTION 4'h1
`define PTM_OFS_INTCTL 4'h2
`define PTM_OFS_EVT_STAT 4'h3
`define PTM_OFS_EVT_MASK 4'h4
`define PTM_OFS_WDT_CFG 4'h5

// ----------------------------------------
// Option register fields
// ----------------------------------------
`define PTM_OPT_PS_LSB 0
`define PTM_OPT_PS_MSB 2
`define PTM_OPT_BYPASS 3
`define PTM_OPT_EDGE 4
`define PTM_OPT_EXT_MODE 5
`define PTM_OPT_RESET 8'hFF

// ----------------------------------------
// Interrupt control fields
// ----------------------------------------
`define PTM_IC_GLOBAL_EN 7
`define PTM_IC_PERIPH_EN 6
`define PTM_IC_OVF_EN 5
`define PTM_IC_OVF_FLAG 2

// ----------------------------------------
// Event status and mask fields
// ----------------------------------------
`define PTM_EVT_W 2
`define PTM_EVT_OVF 0
`define PTM_EVT_WDT 1

// ----------------------------------------
// Values
// ----------------------------------------
`define PTM_COUNT_MAX 8'hFF
`define PTM_ZERO8 8'h00
`define PTM_ZERO_EVT 2'h0
`define PTM_WDT_RESET 3'h7

`endif

// ### logic/ptm_prescaler.v
// Power-of-two prescaler, divide by 2 up to 256
`timescale 1ns/10ps
module ptm_prescaler (
   ref_clk,
   reset,
   clear,
   hold,
   step,
   sel,
   level,
   tick
);
   input wire ref_clk;
   input wire reset;
   input wire clear;
   input wire hold;
   input wire step;
   input wire [2:0] sel;
   output wire level;
   output wire tick;

   reg [7:0] cnt_q;
   wire [7:0] low_mask;

   // Low sel+1 bits take part in the division
   assign low_mask = ~(8'hFE << sel);
   assign level = cnt_q[sel];
   assign tick = step & ~hold & ~clear & ((cnt_q & low_mask) == low_mask);

   always @(posedge ref_clk) begin
      if (reset || clear) begin
         cnt_q <= `PTM_ZERO8;
      end else if (step && !hold) begin
         cnt_q <= cnt_q + 8'h01;
      end
   end
endmodule // ptm_prescaler

// ### verif/ptm_timer_props.sv
// Port-level assertions for the prescaled 8-bit timer
`timescale 1ns/10ps
module ptm_timer_props (
   input wire ref_clk,
   input wire reset,
   input wire [3:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   input wire [7:0] reg_rdata,
   input wire ext_count_input,
   input wire sleep_mode,
   input wire irq,
   input wire watchdog_tick
);
   // ----------------------------------------
   // Shadows of software writes and reads, and of sleep state
   // ----------------------------------------
   reg [7:0] opt_q;
   reg [7:0] last_q;
   reg [1:0] mask_q;
   reg [1:0] ie_q;
   reg quiet_q;
   reg rd0_q;
   reg slp_q;
   reg frz_q;
   always @(posedge ref_clk) begin
      slp_q <= sleep_mode;
      last_q <= rd0_q ? reg_rdata : last_q;
      if (reset) begin
         opt_q <= 8'hFF;
         mask_q <= 2'h0;
         ie_q <= 2'h0;
         quiet_q <= 1'b1;
         rd0_q <= 1'b0;
         frz_q <= 1'b0;
      end else begin
         if (reg_wr && reg_addr == 4'h1)
            opt_q <= reg_wdata;
         if (reg_wr && reg_addr == 4'h4)
            mask_q <= reg_wdata[1:0];
         if (reg_wr && reg_addr == 4'h2)
            ie_q <= {reg_wdata[7], reg_wdata[5]};
         quiet_q <= (mask_q == 2'h0) && (ie_q != 2'h3);
         rd0_q <= reg_rd && reg_addr == 4'h0;
         // Only a read taken inside a sleep span may be compared with the next
         if (!sleep_mode || (reg_wr && reg_addr == 4'h0))
            frz_q <= 1'b0;
         else if (rd0_q && slp_q)
            frz_q <= 1'b1;
      end
   end
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);
   a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("read data not zero outside answer cycle");
   a_unmapped_read: assert property (reg_rd && reg_addr > 4'h5 |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   a_option_back: assert property (reg_rd && reg_addr == 4'h1 |=> reg_rdata == opt_q)
      else $error("option read differs from written value");
   a_intctl_spare: assert property (reg_rd && reg_addr == 4'h2 |=> reg_rdata[4:3] == 2'h0)
      else $error("spare control bits not zero");
   a_irq_quiet: assert property (quiet_q |-> !irq)
      else $error("interrupt with nothing enabled");
   a_irq_enable: assert property (reg_wr && reg_addr == 4'h2 && reg_wdata[7] && reg_wdata[5]
      && reg_wdata[2] |-> ##2 irq)
      else $error("enabled flag gave no interrupt");
   a_wdt_single: assert property (watchdog_tick |=> !watchdog_tick)
      else $error("watchdog tick longer than one cycle");
   a_sleep_frozen: assert property (rd0_q && frz_q |-> reg_rdata == last_q)
      else $error("count moved during sleep");
endmodule // ptm_timer_props

bind ptm_timer ptm_timer_props u_props (.ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .ext_count_input(ext_count_input), .sleep_mode(sleep_mode), .irq(irq),
   .watchdog_tick(watchdog_tick));

// ### verif/ptm_ext_src.sv
// Model of the external count source on the count pin
`timescale 1ns/10ps
module ptm_ext_src (
   input wire ref_clk,
   output reg pin
);
   // ----------------------------------------
   // Pulse train, idle low
   // ----------------------------------------
   initial pin = 1'b0;
   // Levels last longer than an instruction cycle so both samples see them
   task send(input integer pulses, input integer half);
      begin
         repeat (pulses) begin
            pin <= 1'b1;
            repeat (half) @(posedge ref_clk);
            pin <= 1'b0;
            repeat (half) @(posedge ref_clk);
         end
      end
   endtask
endmodule // ptm_ext_src

// ### verif/tb.sv
// Self-checking bench for the prescaled 8-bit timer
`timescale 1ns/10ps
`include "ptm_defs.vh"
module tb;
   reg ref_clk, reset, reg_wr, reg_rd, sleep_mode;
   reg [3:0] reg_addr;
   reg [7:0] reg_wdata, a, b;
   wire [7:0] reg_rdata;
   wire ext_count_input, irq, watchdog_tick;
   integer failures, n_compared, k;
   ptm_timer dut (.ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_count_input(ext_count_input),
      .sleep_mode(sleep_mode), .irq(irq), .watchdog_tick(watchdog_tick));
   ptm_ext_src src (.ref_clk(ref_clk), .pin(ext_count_input));
   initial begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end
   // ----------------------------------------
   // Bus and check tasks
   // ----------------------------------------
   task chk(input [7:0] got, input [7:0] exp);
      begin
         n_compared = n_compared + 1;
         if (got !== exp) begin
            failures = failures + 1;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask
   task cyc(input integer n);
      begin
         repeat (n) @(posedge ref_clk);
         #1;
      end
   endtask
   task wr(input [3:0] ad, input [7:0] d);
      begin
         @(posedge ref_clk);
         reg_addr <= ad;
         reg_wdata <= d;
         reg_wr <= 1'b1;
         @(posedge ref_clk);
         reg_wr <= 1'b0;
      end
   endtask
   task rd(input [3:0] ad, output [7:0] d);
      begin
         @(posedge ref_clk);
         reg_addr <= ad;
         reg_rd <= 1'b1;
         @(posedge ref_clk);
         reg_rd <= 1'b0;
         #1 d = reg_rdata;
      end
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task t_regs;
      begin
         rd(`PTM_OFS_COUNT, a);
         chk(a, 8'h00);
         rd(`PTM_OFS_OPTION, a);
         chk(a, `PTM_OPT_RESET);
         rd(`PTM_OFS_INTCTL, a);
         chk(a, 8'h00);
         rd(`PTM_OFS_WDT_CFG, a);
         chk(a & 8'h07, 8'h07);
         wr(4'h9, 8'h5A);
         rd(4'h9, a);
         chk(a, 8'h00);
      end
   endtask
   // Spans are whole prescale periods, so the phase at start does not matter
   task t_rate;
      begin
         for (k = 0; k < 9; k = k + 1) begin
            wr(`PTM_OFS_OPTION, (k == 8) ? 8'h08 : {5'h00, k[2:0]});
            wr(`PTM_OFS_COUNT, 8'hFE);
            rd(`PTM_OFS_COUNT, a);
            cyc(((k == 8) ? 12 : 24 << k) - 2);
            rd(`PTM_OFS_COUNT, b);
            chk(b - a, 8'h03);
         end
         rd(`PTM_OFS_INTCTL, a);
         chk(a, 8'h04);
         cyc(30);
         rd(`PTM_OFS_INTCTL, a);
         chk(a, 8'h04);
         wr(`PTM_OFS_INTCTL, 8'h00);
         rd(`PTM_OFS_INTCTL, a);
         chk(a, 8'h00);
      end
   endtask
   task t_clear;
      begin
         wr(`PTM_OFS_OPTION, 8'h07);
         wr(`PTM_OFS_COUNT, 8'h00);
         cyc(900);
         wr(`PTM_OFS_COUNT, 8'h00);
         cyc(900);
         rd(`PTM_OFS_COUNT, a);
         chk(a, 8'h00);
         cyc(300);
         rd(`PTM_OFS_COUNT, a);
         chk(a, 8'h01);
      end
   endtask
   task t_irq;
      begin
         // Drop events left over from earlier scenarios
         rd(`PTM_OFS_EVT_STAT, a);
         wr(`PTM_OFS_INTCTL, 8'h84);
         cyc(3);
         chk(irq, 1'b0);
         wr(`PTM_OFS_INTCTL, 8'hA4);
         cyc(3);
         chk(irq, 1'b1);
         wr(`PTM_OFS_INTCTL, 8'h00);
         wr(`PTM_OFS_OPTION, 8'h08);
         wr(`PTM_OFS_EVT_MASK, 8'h01);
         cyc(2);
         chk(irq, 1'b0);
         wr(`PTM_OFS_COUNT, 8'hFF);
         cyc(8);
         chk(irq, 1'b1);
         rd(`PTM_OFS_EVT_STAT, a);
         chk(a & 8'h01, 8'h01);
         rd(`PTM_OFS_EVT_STAT, a);
         chk(a & 8'h01, 8'h00);
         cyc(2);
         chk(irq, 1'b0);
         wr(`PTM_OFS_EVT_MASK, 8'h00);
      end
   endtask
   task t_ext;
      begin
         for (k = 0; k < 4; k = k + 1) begin
            wr(`PTM_OFS_OPTION, {2'b00, 1'b1, k[0], ~k[1], 3'b000});
            // Edge polarity change may look like an edge; let it pass first
            cyc(8);
            wr(`PTM_OFS_COUNT, 8'h00);
            src.send(4, 6);
            cyc(20);
            rd(`PTM_OFS_COUNT, a);
            chk(a, k[1] ? 8'h02 : 8'h04);
         end
      end
   endtask
   task t_sleep;
      begin
         wr(`PTM_OFS_OPTION, 8'h08);
         sleep_mode <= 1'b1;
         cyc(4);
         wr(`PTM_OFS_COUNT, 8'hFF);
         wr(`PTM_OFS_INTCTL, 8'hA0);
         rd(`PTM_OFS_COUNT, a);
         chk(a, 8'hFF);
         cyc(60);
         rd(`PTM_OFS_COUNT, b);
         chk(b, 8'hFF);
         chk(irq, 1'b0);
         @(posedge ref_clk);
         sleep_mode <= 1'b0;
         cyc(8);
         chk(irq, 1'b1);
         wr(`PTM_OFS_INTCTL, 8'h00);
      end
   endtask
   task t_wdt;
      begin
         wr(`PTM_OFS_WDT_CFG, 8'h00);
         rd(`PTM_OFS_EVT_STAT, a);
         k = 0;
         while (watchdog_tick !== 1'b1 && k < 2000) begin
            cyc(1);
            k = k + 1;
         end
         chk(k < 2000, 1'b1);
         // Select 0 divides by two instruction cycles of four clocks
         cyc(1);
         k = 1;
         while (watchdog_tick !== 1'b1 && k < 100) begin
            cyc(1);
            k = k + 1;
         end
         chk(k[7:0], 8'h08);
         rd(`PTM_OFS_EVT_STAT, a);
         chk(a & 8'h02, 8'h02);
      end
   endtask
   // ----------------------------------------
   // Sequence and verdict
   // ----------------------------------------
   task end_sim;
      begin
         $display("Compared %0d, mismatches %0d", n_compared, failures);
         if (failures == 0 && n_compared > 0)
            $display("STATUS OK");
         else
            $display("STATUS NOT OK");
         $finish;
      end
   endtask
   initial begin
      failures = 0;
      n_compared = 0;
      reset = 1'b1;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      sleep_mode = 1'b0;
      reg_addr = 4'h0;
      reg_wdata = 8'h00;
      repeat (16) @(posedge ref_clk);
      reset <= 1'b0;
      cyc(1);
      t_regs;
      t_rate;
      t_clear;
      t_irq;
      t_ext;
      t_sleep;
      t_wdt;
      end_sim;
   end
   initial begin
      repeat (50000) @(posedge ref_clk);
      failures = failures + 1;
      end_sim;
   end
endmodule // tb
